// >>> hw/rscap_top.v
// Reset strap capture, identification registers and sync/flag terminal drive
//
// Notes on behaviour
// - Horizontal sync aligned with video data; rising edge position set by host.
// - Vertical sync output timed against the emitted video data stream.
// - Line-phase mode: flag high on noninverted line, low on inverted line.
// - Horizontal-lock mode: flag high while horizontal loop is locked.
// - Line-phase terminal is an input in reset; with genlock, field picks host mode.
// - Every strap terminal is sampled while reset is asserted and configures modes or identification.
// - Strap terminals are weak-pulldown inputs in reset, normal function afterwards.
// - Eight low chroma straps form vendor identification low byte, register 004.
// - Eight low luma straps form vendor identification high byte, register 005.
// - Eight auxiliary port straps form device identification low byte, register 006.
// - Device id high byte: chroma 9:8, luma 9:8, hsync, vsync, host address.
// - Active-video strap sets video and sync output enables, control bits 4, 3.
// - Clock-enable strap sets clock enable bit 0 of control register 03.
// - Active-video strap high: outputs drive after reset; low: stay high impedance.
`timescale 1ns/1ps
`default_nettype none
`include "rscap_defs.vh"

module rscap_top (
	input  wire        core_clk_i,
	input  wire        rst_i,
	// Video data from the decoder core
	input  wire [9:0]  video_luma_i,
	input  wire [9:0]  video_chroma_i,
	input  wire        video_active_i,
	input  wire        line_start_i,
	input  wire        vsync_i,
	input  wire        field_odd_i,
	input  wire        vlock_i,
	input  wire        line_noninverted_i,
	input  wire        hlock_i,
	input  wire        genlock_i,
	// Terminals, each as input, output and active low output enable
	input  wire [9:0]  luma_bus_i,
	output wire [9:0]  luma_bus_o,
	output wire [9:0]  luma_bus_oe_n_o,
	input  wire [9:0]  chroma_bus_i,
	output wire [9:0]  chroma_bus_o,
	output wire [9:0]  chroma_bus_oe_n_o,
	input  wire        horizontal_sync_out_i,
	output wire        horizontal_sync_out_o,
	output wire        horizontal_sync_out_oe_n_o,
	input  wire        vertical_sync_out_i,
	output wire        vertical_sync_out_o,
	output wire        vertical_sync_out_oe_n_o,
	input  wire        active_video_flag_i,
	output wire        active_video_flag_o,
	output wire        active_video_flag_oe_n_o,
	input  wire        field_indicator_i,
	output wire        field_indicator_o,
	output wire        field_indicator_oe_n_o,
	input  wire        line_phase_flag_i,
	output wire        line_phase_flag_o,
	output wire        line_phase_flag_oe_n_o,
	input  wire        genlock_output_i,
	output wire        genlock_output_o,
	output wire        genlock_output_oe_n_o,
	// Input-only strap terminals
	input  wire [7:0]  aux_port_i,
	input  wire [1:0]  host_addr_i,
	input  wire        clock_enable_strap_i,
	// Reset-time pulldown enable for all strap terminals
	output reg         strap_pulldown_o,
	// Configuration results
	output reg  [2:0]  host_mode_o,
	output reg         clk_en_o,
	// Host port register access
	input  wire [7:0]  host_addr_sel_i,
	input  wire        host_wr_i,
	input  wire        host_rd_i,
	input  wire [7:0]  host_wdata_i,
	output reg  [7:0]  host_rdata_o,
	// Video interface port identification access
	input  wire [7:0]  vip_addr_i,
	input  wire        vip_rd_i,
	output reg  [7:0]  vip_rdata_o
);

	// --------------------------------------------------------------------
	// Control registers
	// --------------------------------------------------------------------
	reg  [7:0]  misc_control_q;
	reg  [7:0]  sync_control_q;
	reg  [11:0] hsync_start_q;
	reg  [11:0] line_count_q;
	reg  [11:0] line_count_d;
	reg         hsync_d;
	reg  [11:0] hsync_ofs_d;
	reg  [7:0]  misc_seed;
	wire [9:0]  luma_strap;
	wire [9:0]  chroma_strap;
	wire        hsync_strap;
	wire        vsync_strap;
	wire        active_video_flag_strap;
	wire        field_strap;
	wire        phase_strap;
	wire        genlock_output_strap;
	wire        video_oe;
	wire        sync_oe;
	wire        phase_drive;
	wire        field_drive;

	// Output enables come from the control register, so a host write can move them
	assign video_oe = misc_control_q[`RSCAP_MISC_VIDEO_OE];
	assign sync_oe  = misc_control_q[`RSCAP_MISC_SYNC_OE];

	// Reset image of the control register; bits with no strap start clear
	always @* begin
		misc_seed                       = 8'h00;
		misc_seed[`RSCAP_MISC_VIDEO_OE] = active_video_flag_i;
		misc_seed[`RSCAP_MISC_SYNC_OE]  = active_video_flag_i;
		misc_seed[`RSCAP_MISC_CLK_EN]   = clock_enable_strap_i;
	end

	// Host writes; during reset the strap levels seed the control bits.
	// Reset outranks a host write, so a write issued in reset is lost.
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			misc_control_q <= misc_seed;
			sync_control_q <= `RSCAP_SYNC_CONTROL_RST;
			hsync_start_q  <= `RSCAP_HSYNC_START_RST;
		end else if (host_wr_i) begin
			case (host_addr_sel_i)
				`RSCAP_MISC_CONTROL: begin
					misc_control_q <= host_wdata_i;
				end
				`RSCAP_SYNC_CONTROL: begin
					sync_control_q <= host_wdata_i;
				end
				`RSCAP_HSYNC_START_LO: begin
					hsync_start_q[7:0] <= host_wdata_i;
				end
				`RSCAP_HSYNC_START_HI: begin
					hsync_start_q[11:8] <= host_wdata_i[3:0];
				end
				default: begin
					misc_control_q <= misc_control_q;
				end
			endcase
		end
	end

	// --------------------------------------------------------------------
	// Horizontal sync timing
	// --------------------------------------------------------------------
	// Counter runs in the same cycle as the data it is registered beside,
	// so sync and data leave the terminals on the same edge.
	// The window is a distance from the programmed start, so a start near
	// the end of the count gives a full pulse that wraps through zero.
	always @* begin
		line_count_d = line_start_i ? 12'h000 : line_count_q + 12'h001;
		hsync_ofs_d  = line_count_d - hsync_start_q;
		hsync_d      = (hsync_ofs_d < `RSCAP_HSYNC_WIDTH);
	end

	// Without line starts the count wraps every 4096 clocks, keeping a cadence
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			line_count_q <= 12'h000;
		end else begin
			line_count_q <= line_count_d;
		end
	end

	// Flag terminal source selection; a mode change shows on the next edge
	// because the selects feed the terminal registers with no retiming
	// line phase polarity
	assign phase_drive = sync_control_q[`RSCAP_SYNC_LINE_MODE] ? hlock_i : line_noninverted_i;
	assign field_drive = sync_control_q[`RSCAP_SYNC_FIELD_MODE] ? vlock_i : field_odd_i;

	// --------------------------------------------------------------------
	// Terminal cells
	// --------------------------------------------------------------------
	// Each cell resamples its terminals on every reset edge, so the last
	// edge before release wins; the enables apply one edge after release.
	// chroma straps captured
	rscap_pin #(.W(10)) u_chroma (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      (chroma_bus_i),
		.drive_i    (video_chroma_i),
		.enable_i   (video_oe),
		.pin_o      (chroma_bus_o),
		.pin_oe_n_o (chroma_bus_oe_n_o),
		.strap_o    (chroma_strap)
	);

	rscap_pin #(.W(10)) u_luma (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      (luma_bus_i),
		.drive_i    (video_luma_i),
		.enable_i   (video_oe),
		.pin_o      (luma_bus_o),
		.pin_oe_n_o (luma_bus_oe_n_o),
		.strap_o    (luma_strap)
	);

	// Sync and flag terminals share one enable; the genlock terminal rides
	// on it too, since it sits among the flags on the board
	// vsync aligned to data
	rscap_pin #(.W(6)) u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.pin_i      ({horizontal_sync_out_i, vertical_sync_out_i, active_video_flag_i,
			field_indicator_i, line_phase_flag_i, genlock_output_i}),
		.drive_i    ({hsync_d, vsync_i, video_active_i, field_drive, phase_drive, genlock_i}),
		.enable_i   (sync_oe),
		.pin_o      ({horizontal_sync_out_o, vertical_sync_out_o, active_video_flag_o,
			field_indicator_o, line_phase_flag_o, genlock_output_o}),
		.pin_oe_n_o ({horizontal_sync_out_oe_n_o, vertical_sync_out_oe_n_o,
			active_video_flag_oe_n_o, field_indicator_oe_n_o, line_phase_flag_oe_n_o,
			genlock_output_oe_n_o}),
		.strap_o    ({hsync_strap, vsync_strap, active_video_flag_strap, field_strap, phase_strap,
			genlock_output_strap})
	);

	// --------------------------------------------------------------------
	// Input-only straps and derived configuration
	// --------------------------------------------------------------------
	// Straps with no output function are held here beside the pulldown
	// control, so every capture shares the same last reset edge
	reg [7:0] aux_strap_q;
	reg [1:0] addr_strap_q;

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			aux_strap_q      <= aux_port_i;
			addr_strap_q     <= host_addr_i;
			strap_pulldown_o <= 1'b1;
			host_mode_o      <= {field_indicator_i, line_phase_flag_i, genlock_output_i};
			clk_en_o         <= clock_enable_strap_i;
		end else begin
			aux_strap_q      <= aux_strap_q;
			addr_strap_q     <= addr_strap_q;
			strap_pulldown_o <= 1'b0;
			host_mode_o      <= {field_strap, phase_strap, genlock_output_strap};
			clk_en_o         <= misc_control_q[`RSCAP_MISC_CLK_EN];
		end
	end

	// --------------------------------------------------------------------
	// Read ports
	// --------------------------------------------------------------------
	// Read data is registered; it appears one edge after the strobe
	// Unmapped offsets read as a fixed value and have no side effects
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			host_rdata_o <= 8'h00;
		end else if (host_rd_i) begin
			case (host_addr_sel_i)
				`RSCAP_MISC_CONTROL:   host_rdata_o <= misc_control_q;
				`RSCAP_SYNC_CONTROL:   host_rdata_o <= sync_control_q;
				`RSCAP_HSYNC_START_LO: host_rdata_o <= hsync_start_q[7:0];
				`RSCAP_HSYNC_START_HI: host_rdata_o <= {4'h0, hsync_start_q[11:8]};
				default:               host_rdata_o <= `RSCAP_READ_UNMAPPED;
			endcase
		end
	end

	// Identification comes only from captured straps, never live terminals
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			vip_rdata_o <= 8'h00;
		end else if (vip_rd_i) begin
			case (vip_addr_i)
				`RSCAP_VENDOR_ID_LOW:  vip_rdata_o <= chroma_strap[7:0];
				`RSCAP_VENDOR_ID_HIGH: vip_rdata_o <= luma_strap[7:0];
				`RSCAP_DEVICE_ID_LOW:  vip_rdata_o <= aux_strap_q;
				`RSCAP_DEVICE_ID_HIGH: vip_rdata_o <= {addr_strap_q, vsync_strap, hsync_strap,
					luma_strap[9:8], chroma_strap[9:8]};
				default:               vip_rdata_o <= `RSCAP_READ_UNMAPPED;
			endcase
		end
	end

	// binds the board: pullup gives one, open gives zero via the pulldown
	// Limitation: straps are judged at the last reset edge only, so a board
	// whose pull-ups settle slowly must keep reset high until they have;
	// the hazard is a strap read as zero after a short reset.

endmodule

`default_nettype wire

// >>> hw/rscap_defs.vh
// Register offsets, field positions and sync timing for the strap capture block
`ifndef RSCAP_DEFS_VH
`define RSCAP_DEFS_VH

// --------------------------------------------------------------------
// Host port register offsets
// --------------------------------------------------------------------
`define RSCAP_MISC_CONTROL     8'h03
`define RSCAP_SYNC_CONTROL     8'h0B
`define RSCAP_HSYNC_START_LO   8'h0C
`define RSCAP_HSYNC_START_HI   8'h0D

// --------------------------------------------------------------------
// Video interface port (identification) offsets
// --------------------------------------------------------------------
`define RSCAP_VENDOR_ID_LOW    8'h04
`define RSCAP_VENDOR_ID_HIGH   8'h05
`define RSCAP_DEVICE_ID_LOW    8'h06
`define RSCAP_DEVICE_ID_HIGH   8'h07

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define RSCAP_MISC_VIDEO_OE    4
`define RSCAP_MISC_SYNC_OE     3
`define RSCAP_MISC_CLK_EN      0
`define RSCAP_SYNC_LINE_MODE   0
`define RSCAP_SYNC_FIELD_MODE  1

// --------------------------------------------------------------------
// Reset values and timing counts
// --------------------------------------------------------------------
`define RSCAP_SYNC_CONTROL_RST 8'h00
`define RSCAP_HSYNC_START_RST  12'h000
`define RSCAP_HSYNC_WIDTH      12'h040
`define RSCAP_READ_UNMAPPED    8'h00

`endif

// >>> hw/rscap_pin.v
// Strap-capable terminal group: output register, enable and reset-time capture
`timescale 1ns/1ps
`default_nettype none

module rscap_pin #(
	parameter W = 1
) (
	input  wire         core_clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] pin_i,
	input  wire [W-1:0] drive_i,
	input  wire         enable_i,
	output reg  [W-1:0] pin_o,
	output reg  [W-1:0] pin_oe_n_o,
	output reg  [W-1:0] strap_o
);

	// --------------------------------------------------------------------
	// Capture and drive
	// --------------------------------------------------------------------
	// Every edge with reset high resamples, so the last one before release wins
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			strap_o    <= pin_i;
			pin_o      <= {W{1'b0}};
			pin_oe_n_o <= {W{1'b1}};
		end else begin
			strap_o    <= strap_o;
			pin_o      <= drive_i;
			pin_oe_n_o <= {W{~enable_i}};
		end
	end

endmodule

`default_nettype wire

// >>> sim/rscap_assertions.sv
// Checker on the strap capture top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "rscap_defs.vh"
module rscap_assertions (
	input wire logic core_clk_i, rst_i, horizontal_sync_out_i, vertical_sync_out_i,
	input wire logic active_video_flag_i, field_indicator_i, line_phase_flag_i,
	input wire logic genlock_output_i, clock_enable_strap_i, vsync_i, vip_rd_i,
	input wire logic strap_pulldown_o, clk_en_o, horizontal_sync_out_oe_n_o,
	input wire logic vertical_sync_out_o, vertical_sync_out_oe_n_o,
	input wire logic [9:0] luma_bus_i, chroma_bus_i, luma_bus_oe_n_o,
	input wire logic [7:0] aux_port_i, vip_addr_i, vip_rdata_o,
	input wire logic [1:0] host_addr_i,
	input wire logic [2:0] host_mode_o
);
	logic [36:0] cap;
	wire  [7:0]  idv;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// Own copy of the straps, last edge of reset wins
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			cap <= {luma_bus_i, chroma_bus_i, horizontal_sync_out_i, vertical_sync_out_i,
				active_video_flag_i, field_indicator_i, line_phase_flag_i,
				genlock_output_i, aux_port_i, host_addr_i, clock_enable_strap_i};
		end
	end

	// Expected identification byte for the addressed place
	assign idv = (vip_addr_i == `RSCAP_VENDOR_ID_LOW) ? cap[24:17] :
		(vip_addr_i == `RSCAP_VENDOR_ID_HIGH) ? cap[34:27] :
		(vip_addr_i == `RSCAP_DEVICE_ID_LOW) ? cap[10:3] :
		(vip_addr_i == `RSCAP_DEVICE_ID_HIGH) ?
		{cap[2:1], cap[15], cap[16], cap[36:35], cap[26:25]} : `RSCAP_READ_UNMAPPED;

	// --------
	// Checks
	// --------
	pd_release_a: assert property ($fell(rst_i) |=> !strap_pulldown_o)
		else $error("pulldown still on after reset");
	bus_oe_a: assert property ($fell(rst_i) |=> luma_bus_oe_n_o == {10{!cap[14]}})
		else $error("video bus enable wrong after reset");
	sync_oe_a: assert property ($fell(rst_i) |=> horizontal_sync_out_oe_n_o == !cap[14])
		else $error("sync enable wrong after reset");
	id_read_a: assert property (vip_rd_i |=> vip_rdata_o == $past(idv))
		else $error("identification byte wrong");
	rdata_hold_a: assert property (!vip_rd_i |=> $stable(vip_rdata_o))
		else $error("read data moved without a read");
	clk_en_a: assert property ($fell(rst_i) |-> clk_en_o == cap[0])
		else $error("clock enable not from strap");
	host_mode_a: assert property (host_mode_o == cap[13:11])
		else $error("host mode not from straps");
	vsync_follow_a: assert property (!vertical_sync_out_oe_n_o |->
		vertical_sync_out_o == $past(vsync_i)) else $error("vertical sync misaligned");

	cover property ($fell(rst_i) && !cap[14]);
	cover property (vip_rd_i && vip_addr_i == `RSCAP_DEVICE_ID_HIGH);
	cover property (!vertical_sync_out_oe_n_o && vsync_i);
endmodule
`default_nettype wire

// >>> sim/rscap_board.sv
// Board model of the strap terminals
`timescale 1ns/1ps
`default_nettype none
module rscap_board (
	input  wire logic        core_clk_i,
	input  wire logic        pd_i,
	input  wire logic [25:0] s_i,
	input  wire logic [25:0] o_i,
	input  wire logic [25:0] oe_n_i,
	output logic      [25:0] lvl_o
);
	logic t_q = 1'b0;

	// Open lines wander so a stale level cannot pass
	always @(posedge core_clk_i) begin
		t_q <= ~t_q;
	end

	assign lvl_o = (~oe_n_i & o_i) | (oe_n_i & (s_i | {26{~pd_i & t_q}}));
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the strap capture block
`timescale 1ns/1ps
`default_nettype none
`include "rscap_defs.vh"
module tb;
	logic c = 1'b0, rs = 1'b1, vsy = 1'b0, lni = 1'b0, hl = 1'b0, hw = 1'b0, hr = 1'b0, vr = 1'b0;
	logic ls = 1'b0;
	logic [36:0] st = 37'h0;
	logic [9:0] vl = 10'h000;
	logic [7:0] ha = 8'h00, wd = 8'h00;
	wire [25:0] lv, po, pe;
	wire [7:0] hd, vd;
	wire [2:0] hm;
	wire pd, ce;
	int n_errors = 0, comparisons = 0;

	initial forever #5 c = ~c;

	rscap_top u_dut (.core_clk_i(c), .rst_i(rs), .video_luma_i(vl), .video_chroma_i(~vl),
		.video_active_i(vsy), .line_start_i(ls), .vsync_i(vsy), .field_odd_i(lni),
		.vlock_i(hl), .line_noninverted_i(lni), .hlock_i(hl), .genlock_i(lni),
		.luma_bus_i(lv[25:16]), .luma_bus_o(po[25:16]), .luma_bus_oe_n_o(pe[25:16]),
		.chroma_bus_i(lv[15:6]), .chroma_bus_o(po[15:6]), .chroma_bus_oe_n_o(pe[15:6]),
		.horizontal_sync_out_i(lv[5]), .horizontal_sync_out_o(po[5]),
		.horizontal_sync_out_oe_n_o(pe[5]), .vertical_sync_out_i(lv[4]),
		.vertical_sync_out_o(po[4]), .vertical_sync_out_oe_n_o(pe[4]),
		.active_video_flag_i(lv[3]), .active_video_flag_o(po[3]),
		.active_video_flag_oe_n_o(pe[3]), .field_indicator_i(lv[2]),
		.field_indicator_o(po[2]), .field_indicator_oe_n_o(pe[2]), .line_phase_flag_i(lv[1]),
		.line_phase_flag_o(po[1]), .line_phase_flag_oe_n_o(pe[1]), .genlock_output_i(lv[0]),
		.genlock_output_o(po[0]), .genlock_output_oe_n_o(pe[0]), .aux_port_i(st[10:3]),
		.host_addr_i(st[2:1]), .clock_enable_strap_i(st[0]), .strap_pulldown_o(pd),
		.host_mode_o(hm), .clk_en_o(ce), .host_addr_sel_i(ha), .host_wr_i(hw),
		.host_rd_i(hr), .host_wdata_i(wd), .host_rdata_o(hd), .vip_addr_i(ha),
		.vip_rd_i(vr), .vip_rdata_o(vd));
	rscap_board u_board (.core_clk_i(c), .pd_i(pd), .s_i(st[36:11]), .o_i(po),
		.oe_n_i(pe), .lvl_o(lv));

	task chk(input logic [9:0] s, input logic [9:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	task hwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge c);
		ha <= a;
		wd <= d;
		hw <= 1'b1;
		@(posedge c);
		hw <= 1'b0;
	endtask

	// One read on the host port (p low) or the identification port (p high)
	task rd(input logic p, input logic [7:0] a, input logic [7:0] e);
		@(posedge c);
		ha <= a;
		hr <= !p;
		vr <= p;
		@(posedge c);
		hr <= 1'b0;
		vr <= 1'b0;
		#1 chk(p ? vd : hd, e);
	endtask

	// Reset with a strap set, then check everything loaded from it
	task run(input logic [36:0] k);
		logic [7:0] ex [5];
		ex = '{k[24:17], k[34:27], k[10:3], {k[2:1], k[15], k[16], k[36:35], k[26:25]}, 8'h00};
		@(posedge c);
		st <= k;
		rs <= 1'b1;
		repeat (4) @(posedge c);
		#1 chk(pd, 1'b1);
		chk(pe[25:16], 10'h3FF);
		chk(pe[15:6], 10'h3FF);
		@(posedge c);
		rs <= 1'b0;
		@(posedge c);
		#1 chk(pd, 1'b0);
		chk(pe[25:16], {10{!k[14]}});
		chk(pe[15:6], {10{!k[14]}});
		chk(pe[5:0], {6{!k[14]}});
		chk(hm, k[13:11]);
		chk(ce, k[0]);
		@(posedge c);
		st <= ~k;
		rd(1'b0, `RSCAP_MISC_CONTROL, {3'h0, k[14], k[14], 2'h0, k[0]});
		for (int i = 0; i < 5; i++) begin
			rd(1'b1, 8'(`RSCAP_VENDOR_ID_LOW + i), ex[i]);
		end
		chk(hm, k[13:11]);
	endtask

	task conclude;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Driven strap set, then the flag modes and sync window, then a second driven set
	initial begin
		run({10'h2A5, 10'h15A, 6'h2D, 8'hC3, 2'h2, 1'h0});
		hwr(8'h30, 8'hFF);
		rd(1'b0, 8'h30, `RSCAP_READ_UNMAPPED);
		for (int j = 0; j < 4; j++) begin
			hwr(`RSCAP_SYNC_CONTROL, 8'((j >> 1) * 3));
			lni <= j[0] ^ j[1];
			hl <= !(j[0] ^ j[1]);
			vsy <= j[0];
			vl <= 10'h3C1 ^ 10'(j);
			repeat (3) @(posedge c);
			#1 chk(po[1], j[0]);
			chk(po[4], j[0]);
			chk(po[25:16], 10'h3C1 ^ 10'(j));
			chk(po[15:6], ~(10'h3C1 ^ 10'(j)));
			chk(po[3], j[0]);
			chk(po[2], j[0]);
			chk(po[0], j[0] ^ j[1]);
		end
		// Sync start at 0x10: low through count 15, high for the width, then low
		hwr(`RSCAP_HSYNC_START_LO, 8'h10);
		hwr(`RSCAP_HSYNC_START_HI, 8'h00);
		rd(1'b0, `RSCAP_HSYNC_START_LO, 8'h10);
		rd(1'b0, `RSCAP_HSYNC_START_HI, 8'h00);
		@(posedge c);
		ls <= 1'b1;
		@(posedge c);
		ls <= 1'b0;
		repeat (15) @(posedge c);
		#1 chk(po[5], 1'b0);
		@(posedge c);
		#1 chk(po[5], 1'b1);
		repeat (`RSCAP_HSYNC_WIDTH - 1) @(posedge c);
		#1 chk(po[5], 1'b1);
		@(posedge c);
		#1 chk(po[5], 1'b0);
		run({10'h0F0, 10'h30F, 6'h12, 8'h3C, 2'h1, 1'h1});
		conclude;
	end

	// Watchdog against a hang
	initial begin
		#100000;
		n_errors++;
		conclude;
	end
endmodule
bind rscap_top rscap_assertions u_chk (.*);
`default_nettype wire
